/* File: rtl/asf_status.v */
`timescale 1ns/1ps
`include "asf_regs.vh"
// Operation
// R1: an 8-bit status register resets to 0x80.
// R2: with status append on, the status byte follows each data read.
// R3: ready bit drives the dout/ready pin when selected and no read runs.
// R4: ready clears to 0 when a new result lands in the data register.
// R5: in calibration, ready clears when the calibration result is written.
// R6: reading the data register sets ready back to 1.
// R7: bit 6 flags over/underrange and the result is clamped to full scale.
// R8: the range flag is refreshed on each result write.
// R9: bit 5 sets on a register write with a failing crc.
// R10: reading the status register clears the crc error flag.
// R11: with integrity check on, bit 4 sets on a checksum mismatch.
// R12: bit 4 holds until the check enable is cleared, then clears.
// R13: bits 3:2 read as zero.
// R14: bits 1:0 give the channel of the result in the data register; the code also loads them on calibration writes, which keep data_q.
// R15: the host reads status with a command byte 0, read, address 000000.
// R16: a write to the mode register sets ready and restarts conversion.
// R17: the status byte is captured before the crc flag clears.
module asf_status #(
  parameter DW = `ASF_DATA_W
) (
  input wire core_clk,
  input wire rst,
  // serial link pins
  input wire sclk,
  input wire cs_n,
  input wire din,
  output reg dout_rdy,
  // conversion engine
  input wire result_wr,
  input wire cal_active,
  input wire [DW-1:0] result_raw,
  input wire range_over,
  input wire range_under,
  input wire [1:0] result_chan,
  // interface configuration and checks
  input wire status_append,
  input wire reg_check_en,
  input wire checksum_mismatch,
  input wire wr_crc_fail,
  // outputs
  output reg [DW-1:0] data_q,
  output reg mode_write,
  output reg [7:0] status_q
);
  localparam ST_CMD = 2'd0;
  localparam ST_RD = 2'd1;
  localparam ST_WR = 2'd2;

  wire sclk_s;
  wire cs_n_s;
  wire din_s;
  asf_sync #(.W(3), .INIT(`ASF_PIN_IDLE)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({sclk, cs_n, din}),
    .q({sclk_s, cs_n_s, din_s})
  );

  reg sclk_prev_q;
  reg [1:0] st_q;
  reg [5:0] bitcnt_q;
  reg [5:0] len_q;
  reg [7:0] cmd_q;
  reg [5:0] target_register_index_q;
  reg [DW+7:0] shift_q;
  reg rdy_q;
  reg adc_err_q;
  reg crc_err_q;
  reg reg_err_q;
  reg [1:0] chan_q;
  reg chk_en_prev_q;

  wire rise = sclk_s & ~sclk_prev_q;
  wire fall = ~sclk_s & sclk_prev_q;
  wire active = ~cs_n_s;
  wire [7:0] cmd_next = {cmd_q[6:0], din_s};
  wire [7:0] status_now = {rdy_q, adc_err_q, crc_err_q, reg_err_q,
    2'b00, chan_q}; // [R13] [R14]
  wire cmd_done = active & rise & (st_q == ST_CMD) & (bitcnt_q == 6'd7);
  wire is_read = cmd_next[`ASF_CMD_RW];
  wire rd_status = cmd_done & is_read &
    (cmd_next[5:0] == `ASF_STATUS_ADDR);
  wire rd_data = cmd_done & is_read & (cmd_next[5:0] == `ASF_DATA_ADDR);
  wire wr_done = active & rise & (st_q == ST_WR) & (bitcnt_q == len_q);
  wire mode_wr = wr_done & (target_register_index_q == `ASF_ADCMODE_ADDR);

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b1;
      st_q <= ST_CMD;
      bitcnt_q <= 6'd0;
      len_q <= 6'd0;
      cmd_q <= 8'h00;
      target_register_index_q <= 6'd0;
      shift_q <= {(DW+8){1'b0}};
      dout_rdy <= 1'b1;
      mode_write <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      mode_write <= mode_wr; // [R16]
      if (!active)
      begin
        st_q <= ST_CMD;
        bitcnt_q <= 6'd0;
        dout_rdy <= 1'b1;
      end
      else
      begin
        case (st_q)
          ST_CMD:
          begin
            // pin follows ready as soon as selected, not only on clocks
            dout_rdy <= rdy_q; // [R3]
            if (rise)
            begin
              cmd_q <= cmd_next;
              bitcnt_q <= bitcnt_q + 6'd1;
              if (bitcnt_q == 6'd7)
              begin
                bitcnt_q <= 6'd0;
                target_register_index_q <= cmd_next[5:0];
                if (cmd_next[`ASF_CMD_WEN])
                  st_q <= ST_CMD;
                else if (is_read)
                begin
                  st_q <= ST_RD;
                  if (rd_data && status_append)
                  begin
                    shift_q <= {data_q, status_now}; // [R2]
                    len_q <= DW[5:0] + 6'd8;
                  end
                  else if (rd_data)
                  begin
                    shift_q <= {data_q, 8'h00};
                    len_q <= DW[5:0];
                  end
                  else
                  begin
                    // capture before the crc flag is cleared [R17]
                    shift_q <= {status_now, {DW{1'b0}}};
                    len_q <= 6'd8;
                  end
                end
                else
                begin
                  st_q <= ST_WR;
                  len_q <= 6'd7;
                end
              end
            end
          end
          ST_RD:
          begin
            if (fall)
            begin
              dout_rdy <= shift_q[DW+7];
              shift_q <= {shift_q[DW+6:0], 1'b0};
              bitcnt_q <= bitcnt_q + 6'd1;
            end
            if (rise && bitcnt_q == len_q)
            begin
              st_q <= ST_CMD;
              bitcnt_q <= 6'd0;
            end
          end
          ST_WR:
          begin
            dout_rdy <= rdy_q; // [R3]
            if (rise)
            begin
              bitcnt_q <= bitcnt_q + 6'd1;
              if (bitcnt_q == len_q)
              begin
                st_q <= ST_CMD;
                bitcnt_q <= 6'd0;
              end
            end
          end
          default:
            st_q <= ST_CMD;
        endcase
      end
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rdy_q <= 1'b1;
      adc_err_q <= 1'b0;
      crc_err_q <= 1'b0;
      reg_err_q <= 1'b0;
      chan_q <= 2'b00;
      chk_en_prev_q <= 1'b0;
      data_q <= {DW{1'b0}};
      status_q <= `ASF_STATUS_RESET; // [R1]
    end
    else
    begin
      chk_en_prev_q <= reg_check_en;
      if (result_wr)
      begin
        rdy_q <= 1'b0; // [R4] [R5]
        adc_err_q <= range_over | range_under; // [R8]
        chan_q <= result_chan; // [R14]
        if (cal_active)
          data_q <= data_q;
        else if (range_over)
          data_q <= `ASF_POS_FS; // [R7]
        else if (range_under)
          data_q <= `ASF_NEG_FS; // [R7]
        else
          data_q <= result_raw;
      end
      else if (rd_data || mode_wr)
        rdy_q <= 1'b1; // [R6] [R16]
      if (wr_crc_fail)
        crc_err_q <= 1'b1; // [R9]
      else if (rd_status)
        crc_err_q <= 1'b0; // [R10]
      if (!reg_check_en)
        reg_err_q <= 1'b0; // [R12]
      else if (chk_en_prev_q && checksum_mismatch)
        reg_err_q <= 1'b1; // [R11]
      status_q <= status_now;
    end
  end
endmodule

/* File: common/asf_regs.vh */
`ifndef ASF_REGS_VH
`define ASF_REGS_VH
`define ASF_STATUS_ADDR 6'h00
`define ASF_ADCMODE_ADDR 6'h01
`define ASF_DATA_ADDR 6'h04
`define ASF_STATUS_RESET 8'h80
`define ASF_PIN_IDLE 3'h7
`define ASF_BIT_RDY 7
`define ASF_BIT_ADCERR 6
`define ASF_BIT_CRCERR 5
`define ASF_BIT_REGERR 4
`define ASF_CMD_WEN 7
`define ASF_CMD_RW 6
`define ASF_DATA_W 24
`define ASF_POS_FS 24'h7f_ffff
`define ASF_NEG_FS 24'h80_0000
`endif

/* File: rtl/asf_sync.v */
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module asf_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      // reset to the idle level so no false edge follows reset
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: sim/asf_status_chk.sv */
`timescale 1ns/1ps
module asf_status_chk (
  input wire core_clk,
  input wire rst,
  input wire cs_n,
  input wire dout_rdy,
  input wire result_wr,
  input wire range_over,
  input wire range_under,
  input wire reg_check_en,
  input wire wr_crc_fail,
  input wire mode_write,
  input wire [7:0] status_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a result write seen two edges on, once status_q has caught up
  sequence s_res;
    result_wr ##2 1'b1;
  endsequence
  a_rst_value: assert property (disable iff (1'b0)
    rst |=> status_q == 8'h80) else $error("bad reset value");
  a_rdy_clear: assert property (s_res |-> !status_q[7])
    else $error("ready not cleared");
  a_range_flag: assert property (s_res |->
    status_q[6] == $past(range_over | range_under, 2))
    else $error("range flag wrong");
  a_rsvd_zero: assert property (status_q[3:2] == 2'b00)
    else $error("reserved bits set");
  a_crc_set: assert property (wr_crc_fail |-> ##2 status_q[5])
    else $error("crc flag not set");
  a_reg_clear: assert property (!reg_check_en |-> ##2 !status_q[4])
    else $error("reg flag not cleared");
  a_mode_rdy: assert property (mode_write |-> ##[1:2] status_q[7])
    else $error("ready not set by mode write");
  a_desel_idle: assert property (cs_n [*5] |-> dout_rdy)
    else $error("pin low while deselected");
endmodule
bind asf_status asf_status_chk asf_status_chk_inst (.*);

/* File: sim/asf_host.sv */
`timescale 1ns/1ps
module asf_host (
  input wire core_clk,
  input wire dout_rdy,
  output reg sclk = 1'b1,
  output reg cs_n = 1'b1,
  output reg din = 1'b1
);
  task sel(input v);
    @(posedge core_clk) cs_n <= v;
  endtask
  // serial clock idles high and runs only inside a frame
  task xfer(input [7:0] cmd, input integer nb, output [31:0] rd);
    integer i;
    begin
      rd = 32'h0000_0000;
      @(posedge core_clk) cs_n <= 1'b0;
      for (i = 0; i < 8 + nb; i = i + 1)
      begin
        repeat (4) @(posedge core_clk);
        sclk <= 1'b0;
        din <= (i < 8) ? cmd[7 - i] : ~din;
        repeat (4) @(posedge core_clk);
        sclk <= 1'b1;
        rd = {rd[30:0], dout_rdy};
      end
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "asf_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  miscompares++; $display("Error %0t: mismatch", $time); end end
module tb_top;
  reg core_clk = 0, rst = 1, result_wr = 0, cal_active = 0;
  reg range_over = 0, range_under = 0, status_append = 0;
  reg reg_check_en = 0, checksum_mismatch = 0, wr_crc_fail = 0;
  reg [1:0] result_chan = 0;
  wire sclk, cs_n, din, dout_rdy, mode_write;
  wire [23:0] data_q;
  wire [7:0] status_q;
  reg [31:0] rd;
  integer miscompares = 0, n_compared = 0, n_mode = 0;
  always @(posedge core_clk)
    if (mode_write)
      n_mode <= n_mode + 1;
  always #25 core_clk = ~core_clk;
  asf_status asf_status_inst (.*, .result_raw(24'h01_2345));
  asf_host asf_host_inst (.*);
  task w(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task res(input [1:0] ch, input o, input u, input c);
    begin
      @(posedge core_clk);
      {result_chan, range_over, range_under, cal_active} <= {ch, o, u, c};
      result_wr <= 1'b1;
      @(posedge core_clk);
      result_wr <= 1'b0;
      w(3);
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial
  begin
    w(12);
    rst <= 1'b0;
    w(2);
    `CHK({status_q, dout_rdy}, {`ASF_STATUS_RESET, 1'b1})
    res(2'd2, 1'b1, 1'b0, 1'b0);
    `CHK({data_q, status_q}, {`ASF_POS_FS, 8'h42})
    asf_host_inst.sel(1'b0);
    w(6);
    `CHK(dout_rdy, 1'b0)
    asf_host_inst.sel(1'b1);
    status_append <= 1'b1;
    asf_host_inst.xfer(8'h44, 32, rd);
    `CHK(rd, {`ASF_POS_FS, 8'h42})
    w(3);
    `CHK(status_q, 8'hc2)
    $display("data test done");
    res(2'd3, 1'b0, 1'b1, 1'b0);
    `CHK({data_q, status_q}, {`ASF_NEG_FS, 8'h43})
    res(2'd1, 1'b0, 1'b0, 1'b0);
    `CHK({data_q, status_q}, {24'h01_2345, 8'h01})
    asf_host_inst.xfer(8'h01, 8, rd);
    w(3);
    `CHK(status_q[7], 1'b1)
    `CHK(n_mode, 1)
    res(2'd1, 1'b0, 1'b0, 1'b1);
    `CHK({data_q, status_q[7]}, {24'h01_2345, 1'b0})
    wr_crc_fail <= 1'b1;
    w(1);
    wr_crc_fail <= 1'b0;
    w(3);
    `CHK(status_q[5], 1'b1)
    asf_host_inst.xfer(8'h40, 8, rd);
    `CHK(rd[6:2], 5'b01000)
    w(3);
    `CHK(status_q[5], 1'b0)
    reg_check_en <= 1'b1;
    w(2);
    checksum_mismatch <= 1'b1;
    w(1);
    checksum_mismatch <= 1'b0;
    w(6);
    `CHK(status_q[4], 1'b1)
    reg_check_en <= 1'b0;
    w(3);
    `CHK(status_q[4], 1'b0)
    $display("flag test done");
    end_sim;
  end
  initial
  begin
    #500_000;
    miscompares++;
    end_sim;
  end
endmodule
